// ==== src/bms_params.svh ====
/*
 * Constants of the burst-mode serial port: configuration bundle layout,
 * word-length counts and reset values.
 * Assumes inclusion by bare name from the serial port design files.
 */
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

// Bit positions in the configuration bundles passed to the link domains
`define BMS_CFG_MODE 0
`define BMS_CFG_SRC 1
`define BMS_CFG_WL 2
`define BMS_CFG_BUF 3
`define BMS_CFG_TOG 4
`define BMS_TX_CFG_W 5
`define BMS_RX_CFG_W 5

// Bits still to come after the first one, per word length
`define BMS_LAST_SHORT 4'h7
`define BMS_LAST_LONG 4'hf

// Reset values
`define BMS_WORD_RST 16'h0000
`define BMS_TX_READY_RST 1'b1
`define BMS_EMPTY_N_RST 1'b0

`endif

// ==== src/bms_pkg.sv ====
/*
 * Types of the burst-mode serial port: transmit and receive state codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bms_pkg;

	typedef enum logic [2:0] {
		tx_idle = 3'b001,
		tx_first = 3'b010,
		tx_shift = 3'b100
	} bms_tx_state_type;

	typedef enum logic [3:0] {
		rx_idle = 4'b0001,
		rx_sync = 4'b0010,
		rx_recv = 4'b0100,
		rx_hold = 4'b1000
	} bms_rx_state_type;

endpackage : bms_pkg

// ==== src/bms_sync.sv ====
/*
 * Three-stage synchroniser for a bundle of levels or toggles; each bit
 * of the output changes only once the second and third stages agree.
 * Assumes the inputs come from another clock domain.
 */
`timescale 1ns/1ps

module bms_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_q;

	// Disagreeing bits hold their old value
	always_comb
	begin
		next_q = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule : bms_sync

// ==== src/bms_port.sv ====
/*
 * Burst-mode serial port: transmit holding register on the CPU clock, transmit
 * logic on the transmit bit clock, receive logic on the falling receive
 * bit clock. Assumes the external device drives frame syncs and serial
 * data synchronous to the bit clocks and that configuration is static
 * while a transfer runs.
 */
`timescale 1ns/1ps
`include "bms_params.svh"

// Function
// - Holding write starts a burst transmit
// - Basic variant transfers shortly after write
// - Buffered external waits sync; internal immediate
// - Load sets ready, interrupt, empty_n high
// - Transfer only if empty and rewritten
// - Source select sets sync pin direction
// - Internal sync follows write on second edge
// - Internal sync lasts one bit clock
// - MSB on edge after sync, rest follow
// - Output released after last bit
// - External sync: wait indefinitely, shift register held
// - No rewrite: empty_n low at end
// - Sync during underflow resends stale word
// - Basic delayed sync: copy after send
// - Buffered delayed sync: latest word each sync
// - Receive shifting starts after sync falls
// - Last bit copies to holding, ready, interrupt
// - Overrun when holding unread, variant timing
// - Basic keeps shift word; buffered discards it
// - Buffered read clears overrun, resumes
// - Long receive sync delays every bit
// - Burst mode only when mode select set
// - Underflow halts transmitter, output released
// - Overrun cleared by read or reset
module bms_port (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tx_bit_clock,
	input wire logic rx_bit_clock,
	input wire logic frame_sync_mode_select,
	input wire logic frame_sync_source_select,
	input wire logic word_length_select,
	input wire logic buffered_port_variant,
	input wire logic tx_write,
	input wire logic [15:0] tx_data,
	input wire logic rx_read,
	input wire logic tx_frame_sync_in,
	output logic tx_frame_sync_out,
	output logic tx_frame_sync_en_b,
	output logic serial_data_out,
	output logic serial_data_out_en_b,
	input wire logic rx_frame_sync,
	input wire logic serial_data_in,
	output logic tx_ready_flag,
	output logic tx_interrupt,
	output logic tx_shift_empty_n,
	output logic rx_ready_flag,
	output logic rx_interrupt,
	output logic rx_overrun_flag,
	output logic [15:0] rx_data
);

	// CPU domain state
	logic [15:0] tx_holding_reg, next_tx_holding_reg;
	logic wtog, next_wtog, rtog, next_rtog;
	logic next_tx_ready_flag, next_tx_interrupt, next_rx_ready_flag, next_rx_interrupt;
	logic [15:0] next_rx_data;
	logic txev_seen, rxev_seen;
	logic [1:0] c_tx, c_rx;
	logic tx_ev, rx_ev;

	// Transmit domain state
	bms_pkg::bms_tx_state_type tx_state, next_tx_state;
	logic [15:0] tx_shift_reg, next_tx_shift_reg, shadow, next_shadow, word;
	logic [3:0] bits_left, next_bits_left;
	logic xsr_full, next_xsr_full, pend, next_pend, wseen, fs_last;
	logic next_fs_out, next_sdo, next_sdo_en_b, next_fs_en_b;
	logic tx_rtog, next_tx_rtog, empty_n, next_empty_n;
	logic [`BMS_TX_CFG_W-1:0] t_cfg;
	logic t_mode, t_src, t_wl, t_buf, write_seen;
	logic fs_now, fs_rise, start_now, end_now, xfer, fresh;

	// Receive domain state, clocked on the falling receive edge
	bms_pkg::bms_rx_state_type rx_state, next_rx_state;
	logic [15:0] rx_shift_reg, next_rx_shift_reg, rx_holding_reg, next_rx_holding_reg;
	logic [15:0] word_in;
	logic [3:0] rbits, next_rbits;
	logic rx_full, next_rx_full, overrun, next_overrun;
	logic rx_rtog, next_rx_rtog, rseen;
	logic [`BMS_RX_CFG_W-1:0] r_cfg;
	logic r_mode, r_wl, r_buf, read_ev, last_now, rx_edge;

	assign rx_edge = ~rx_bit_clock;

	bms_sync #(.WIDTH(`BMS_TX_CFG_W)) u_tx_cfg (
		.clk(tx_bit_clock),
		.rst_b(rst_b),
		.d({wtog, buffered_port_variant, word_length_select, frame_sync_source_select,
			frame_sync_mode_select}),
		.q(t_cfg)
	);

	bms_sync #(.WIDTH(`BMS_RX_CFG_W)) u_rx_cfg (
		.clk(rx_edge),
		.rst_b(rst_b),
		.d({rtog, buffered_port_variant, word_length_select, 1'b0, frame_sync_mode_select}),
		.q(r_cfg)
	);

	bms_sync #(.WIDTH(2)) u_tx_stat (
		.clk(clk),
		.rst_b(rst_b),
		.d({tx_rtog, empty_n}),
		.q(c_tx)
	);

	bms_sync #(.WIDTH(2)) u_rx_stat (
		.clk(clk),
		.rst_b(rst_b),
		.d({rx_rtog, overrun}),
		.q(c_rx)
	);

	// CPU side: holding register, flags, interrupts
	assign tx_ev = c_tx[1] != txev_seen;
	assign rx_ev = c_rx[1] != rxev_seen;
	assign tx_shift_empty_n = c_tx[0];
	assign rx_overrun_flag = c_rx[0];

	always_comb
	begin
		next_tx_holding_reg = tx_write ? tx_data : tx_holding_reg;
		next_wtog = wtog ^ tx_write;
		next_rtog = rtog ^ rx_read;
		next_tx_ready_flag = (tx_ready_flag & ~tx_write) | tx_ev;
		next_tx_interrupt = tx_ev;
		next_rx_ready_flag = (rx_ready_flag & ~rx_read) | rx_ev;
		next_rx_interrupt = rx_ev;
		// Holding word is stable until the next transfer, which needs a read first
		next_rx_data = rx_ev ? rx_holding_reg : rx_data;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_holding_reg <= `BMS_WORD_RST;
			wtog <= 1'b0;
			rtog <= 1'b0;
			tx_ready_flag <= `BMS_TX_READY_RST;
			tx_interrupt <= 1'b0;
			rx_ready_flag <= 1'b0;
			rx_interrupt <= 1'b0;
			rx_data <= `BMS_WORD_RST;
			txev_seen <= 1'b0;
			rxev_seen <= 1'b0;
		end
		else
		begin
			tx_holding_reg <= next_tx_holding_reg;
			wtog <= next_wtog;
			rtog <= next_rtog;
			tx_ready_flag <= next_tx_ready_flag;
			tx_interrupt <= next_tx_interrupt;
			rx_ready_flag <= next_rx_ready_flag;
			rx_interrupt <= next_rx_interrupt;
			rx_data <= next_rx_data;
			txev_seen <= c_tx[1];
			rxev_seen <= c_rx[1];
		end
	end

	// Transmit side
	assign t_mode = t_cfg[`BMS_CFG_MODE];
	assign t_src = t_cfg[`BMS_CFG_SRC];
	assign t_wl = t_cfg[`BMS_CFG_WL];
	assign t_buf = t_cfg[`BMS_CFG_BUF];
	assign write_seen = t_cfg[`BMS_CFG_TOG] != wseen;
	assign fs_now = t_src ? tx_frame_sync_out : tx_frame_sync_in;
	assign fs_rise = fs_now & ~fs_last;
	// External sync may start on a stale word; internal sync only follows a load
	assign start_now = t_mode & fs_rise & (xsr_full | ~t_src);
	assign end_now = (tx_state == bms_pkg::tx_shift) && (bits_left == 4'h0);
	assign xfer = t_mode & pend & ~xsr_full & ~start_now & ~(t_buf & ~t_src)
		& ((tx_state == bms_pkg::tx_idle) | end_now);
	assign fresh = start_now & ~xsr_full & pend;
	assign word = xsr_full ? tx_shift_reg : shadow;

	always_comb
	begin
		next_tx_state = tx_state;
		next_tx_shift_reg = tx_shift_reg;
		next_bits_left = bits_left;
		next_sdo = serial_data_out;
		next_sdo_en_b = serial_data_out_en_b;
		next_xsr_full = xsr_full;
		next_pend = pend;
		next_shadow = shadow;
		next_tx_rtog = tx_rtog;
		next_empty_n = empty_n;
		next_fs_out = xfer & t_src;
		next_fs_en_b = ~t_src;
		if (xfer | fresh)
		begin
			next_pend = 1'b0;
			next_tx_rtog = ~tx_rtog;
			next_empty_n = 1'b1;
		end
		// A write seen in the same edge as a transfer stays pending
		if (write_seen)
		begin
			next_pend = 1'b1;
			next_shadow = t_wl ? tx_holding_reg : {tx_holding_reg[7:0], 8'h00};
		end
		if (xfer)
		begin
			next_tx_shift_reg = shadow;
			next_xsr_full = 1'b1;
		end
		if (start_now)
		begin
			next_sdo = word[15];
			next_tx_shift_reg = {word[14:0], 1'b0};
			next_bits_left = t_wl ? `BMS_LAST_LONG : `BMS_LAST_SHORT;
			next_tx_state = bms_pkg::tx_first;
			next_sdo_en_b = 1'b0;
			next_xsr_full = 1'b0;
		end
		else
		begin
			case (tx_state)
				bms_pkg::tx_idle:
				begin
					next_tx_state = bms_pkg::tx_idle;
				end
				bms_pkg::tx_first:
				begin
					// First bit held while a long sync stays high
					if (!fs_now)
					begin
						next_sdo = tx_shift_reg[15];
						next_tx_shift_reg = {tx_shift_reg[14:0], 1'b0};
						next_bits_left = bits_left - 4'h1;
						next_tx_state = bms_pkg::tx_shift;
					end
				end
				bms_pkg::tx_shift:
				begin
					if (end_now)
					begin
						next_tx_state = bms_pkg::tx_idle;
						next_sdo_en_b = 1'b1;
						if (!xfer)
						begin
							next_empty_n = 1'b0;
						end
					end
					else
					begin
						next_sdo = tx_shift_reg[15];
						next_tx_shift_reg = {tx_shift_reg[14:0], 1'b0};
						next_bits_left = bits_left - 4'h1;
					end
				end
				default:
				begin
					next_tx_state = bms_pkg::tx_idle;
				end
			endcase
		end
	end

	always_ff @(posedge tx_bit_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_state <= bms_pkg::tx_idle;
			tx_shift_reg <= `BMS_WORD_RST;
			bits_left <= 4'h0;
			serial_data_out <= 1'b0;
			serial_data_out_en_b <= 1'b1;
			xsr_full <= 1'b0;
			pend <= 1'b0;
			shadow <= `BMS_WORD_RST;
			wseen <= 1'b0;
			fs_last <= 1'b0;
			tx_frame_sync_out <= 1'b0;
			tx_frame_sync_en_b <= 1'b1;
			tx_rtog <= 1'b0;
			empty_n <= `BMS_EMPTY_N_RST;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_shift_reg <= next_tx_shift_reg;
			bits_left <= next_bits_left;
			serial_data_out <= next_sdo;
			serial_data_out_en_b <= next_sdo_en_b;
			xsr_full <= next_xsr_full;
			pend <= next_pend;
			shadow <= next_shadow;
			wseen <= t_cfg[`BMS_CFG_TOG];
			fs_last <= fs_now;
			tx_frame_sync_out <= next_fs_out;
			tx_frame_sync_en_b <= next_fs_en_b;
			tx_rtog <= next_tx_rtog;
			empty_n <= next_empty_n;
		end
	end

	// Receive side
	assign r_mode = r_cfg[`BMS_CFG_MODE];
	assign r_wl = r_cfg[`BMS_CFG_WL];
	assign r_buf = r_cfg[`BMS_CFG_BUF];
	assign read_ev = r_cfg[`BMS_CFG_TOG] != rseen;
	assign word_in = {rx_shift_reg[14:0], serial_data_in};
	assign last_now = (rx_state == bms_pkg::rx_recv) && (rbits == 4'h1);

	always_comb
	begin
		next_rx_state = rx_state;
		next_rx_shift_reg = rx_shift_reg;
		next_rx_holding_reg = rx_holding_reg;
		next_rbits = rbits;
		next_rx_full = rx_full;
		next_overrun = overrun;
		next_rx_rtog = rx_rtog;
		// Clears come first so that a set in the same edge wins
		if (read_ev)
		begin
			next_rx_full = 1'b0;
			next_overrun = 1'b0;
		end
		case (rx_state)
			bms_pkg::rx_idle:
			begin
				if (r_mode && rx_frame_sync)
				begin
					next_rx_state = bms_pkg::rx_sync;
				end
			end
			bms_pkg::rx_sync:
			begin
				if (!rx_frame_sync)
				begin
					next_rx_shift_reg = word_in;
					next_rbits = r_wl ? `BMS_LAST_LONG : `BMS_LAST_SHORT;
					next_rx_state = bms_pkg::rx_recv;
				end
			end
			bms_pkg::rx_recv:
			begin
				next_rx_shift_reg = word_in;
				next_rbits = rbits - 4'h1;
				if (last_now)
				begin
					next_rx_state = rx_frame_sync ? bms_pkg::rx_sync : bms_pkg::rx_idle;
					if (!rx_full)
					begin
						next_rx_holding_reg = r_wl ? word_in : {8'h00, word_in[7:0]};
						next_rx_full = 1'b1;
						next_rx_rtog = ~rx_rtog;
					end
					else if (r_buf)
					begin
						next_overrun = 1'b1;
					end
					else
					begin
						next_rx_state = bms_pkg::rx_hold;
					end
				end
				else if (rx_frame_sync)
				begin
					// Sync in mid-word aborts and restarts
					next_rx_state = bms_pkg::rx_sync;
				end
			end
			bms_pkg::rx_hold:
			begin
				// Word kept in the shift register; incoming bits are lost
				if (read_ev)
				begin
					next_rx_state = bms_pkg::rx_idle;
				end
				else if (rx_frame_sync)
				begin
					next_overrun = 1'b1;
				end
			end
			default:
			begin
				next_rx_state = bms_pkg::rx_idle;
			end
		endcase
	end

	always_ff @(negedge rx_bit_clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_state <= bms_pkg::rx_idle;
			rx_shift_reg <= `BMS_WORD_RST;
			rx_holding_reg <= `BMS_WORD_RST;
			rbits <= 4'h0;
			rx_full <= 1'b0;
			overrun <= 1'b0;
			rx_rtog <= 1'b0;
			rseen <= 1'b0;
		end
		else
		begin
			rx_state <= next_rx_state;
			rx_shift_reg <= next_rx_shift_reg;
			rx_holding_reg <= next_rx_holding_reg;
			rbits <= next_rbits;
			rx_full <= next_rx_full;
			overrun <= next_overrun;
			rx_rtog <= next_rx_rtog;
			rseen <= r_cfg[`BMS_CFG_TOG];
		end
	end

	// Checks
	sequence s_start;
		start_now;
	endsequence

	sequence s_drive_msb;
		!serial_data_out_en_b ##0 (serial_data_out == $past(word[15]));
	endsequence

	a_msb_first: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		s_start |=> s_drive_msb)
		else $error("MSB not driven after sync");
	a_fs_one_cycle: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		$rose(tx_frame_sync_out) |=> !tx_frame_sync_out)
		else $error("Internal sync too long");
	a_fs_after_load: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		(xfer && t_src) |=> tx_frame_sync_out ##1 (tx_state == bms_pkg::tx_first))
		else $error("Internal sync missing");
	a_release_end: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		(end_now && !start_now) |=> serial_data_out_en_b)
		else $error("Output not released");
	a_underflow_flag: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		(end_now && !xfer && !start_now) |=> !empty_n && serial_data_out_en_b)
		else $error("Underflow not flagged");
	a_load_empty_n: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		(xfer || fresh) |=> empty_n && (tx_rtog != $past(tx_rtog)))
		else $error("Load not signalled");
	a_pin_dir: assert property (@(posedge tx_bit_clock) disable iff (!rst_b)
		##1 (tx_frame_sync_en_b == !$past(t_src)))
		else $error("Sync pin direction wrong");
	a_rx_copy: assert property (@(negedge rx_bit_clock) disable iff (!rst_b)
		(last_now && !rx_full) |=> rx_full && (rx_holding_reg[7:0] == $past(word_in[7:0])))
		else $error("Receive copy missing");
	a_rx_overrun: assert property (@(negedge rx_bit_clock) disable iff (!rst_b)
		(last_now && rx_full && !read_ev && r_buf) |=> overrun && $stable(rx_holding_reg))
		else $error("Buffered overrun missed");
	a_rx_clear: assert property (@(negedge rx_bit_clock) disable iff (!rst_b)
		(read_ev && rx_state != bms_pkg::rx_hold && !last_now) |=> !overrun)
		else $error("Read did not clear overrun");
	a_ready_set: assert property (@(posedge clk) disable iff (!rst_b)
		tx_ev |=> tx_ready_flag && tx_interrupt ##1 !tx_interrupt)
		else $error("Transmit ready not raised");

endmodule : bms_port

// ==== verification/bms_partner.sv ====
/*
 * Far-side serial device: drives frame syncs and receive data, captures
 * transmitted words. Assumes the bench supplies both bit clocks.
 */
`timescale 1ns/1ps

module bms_partner (
	input wire logic tx_bit_clock,
	input wire logic rx_bit_clock,
	input wire logic tx_frame_sync_out,
	input wire logic tx_frame_sync_en_b,
	input wire logic serial_data_out,
	input wire logic serial_data_out_en_b,
	output logic tx_frame_sync_in,
	output logic rx_frame_sync,
	output logic serial_data_in
);
	logic fs_drv = 1'b0;
	logic busy = 1'b0;
	initial rx_frame_sync = 1'b0;
	initial serial_data_in = 1'b0;
	// Wire level of the shared sync pin
	assign tx_frame_sync_in = tx_frame_sync_en_b ? fs_drv : tx_frame_sync_out;
	// Idle data toggles so a stale bit never passes for a valid one
	always @(posedge rx_bit_clock)
		if (!busy) serial_data_in <= ~serial_data_in;

	// Len 0 watches an internal sync; otherwise drives one len cycles long
	task automatic tx_frame(input int len, input int n, output logic [15:0] w,
		output logic ok);
		int k;
		ok = 1'b1;
		w = 16'h0000;
		k = 0;
		@(negedge tx_bit_clock);
		if (len == 0)
		begin
			while (tx_frame_sync_in !== 1'b1 && k < 60)
			begin
				@(negedge tx_bit_clock);
				k++;
			end
			ok = (k < 60);
		end
		else
			fs_drv = 1'b1;
		@(negedge tx_bit_clock);
		if (len == 0) ok &= (tx_frame_sync_in === 1'b0);
		w = {w[14:0], serial_data_out};
		ok &= (serial_data_out_en_b === 1'b0);
		// Long sync holds the first bit
		for (k = 1; k < len; k++)
		begin
			@(negedge tx_bit_clock);
			ok &= (serial_data_out === w[0]);
		end
		fs_drv = 1'b0;
		for (k = 1; k < n; k++)
		begin
			@(negedge tx_bit_clock);
			w = {w[14:0], serial_data_out};
			ok &= (serial_data_out_en_b === 1'b0);
		end
		@(negedge tx_bit_clock);
		ok &= (serial_data_out_en_b === 1'b1);
	endtask : tx_frame

	// Data changes on rising edges, the port samples on falling ones
	task automatic rx_frame(input logic [15:0] w, input int n, input int len);
		int k;
		busy = 1'b1;
		@(posedge rx_bit_clock);
		rx_frame_sync = 1'b1;
		repeat (len - 1) @(posedge rx_bit_clock);
		for (k = n - 1; k >= 0; k--)
		begin
			@(posedge rx_bit_clock);
			rx_frame_sync = 1'b0;
			serial_data_in = w[k];
		end
		@(posedge rx_bit_clock);
		busy = 1'b0;
	endtask : rx_frame
endmodule : bms_partner

// ==== verification/test_burst_mode_serial_port.sv ====
/*
 * Self-checking bench of the burst-mode serial port.
 * Assumes the far-side model in bms_partner and free-running bit clocks.
 */
`timescale 1ns/1ps

module test_burst_mode_serial_port;
	logic clk, rst_b, tx_bit_clock, rx_bit_clock, tx_write, rx_read;
	logic frame_sync_mode_select, frame_sync_source_select;
	logic word_length_select, buffered_port_variant;
	logic [15:0] tx_data, rx_data;
	logic tx_frame_sync_in, tx_frame_sync_out, tx_frame_sync_en_b;
	logic serial_data_out, serial_data_out_en_b, rx_frame_sync, serial_data_in;
	logic tx_ready_flag, tx_interrupt, tx_shift_empty_n;
	logic rx_ready_flag, rx_interrupt, rx_overrun_flag;
	int fails = 0, n_checks = 0, tx_cnt = 0, rx_cnt = 0, cycles = 0;

	bms_port bms_port_i (.clk, .rst_b, .tx_bit_clock, .rx_bit_clock,
		.frame_sync_mode_select, .frame_sync_source_select, .word_length_select,
		.buffered_port_variant, .tx_write, .tx_data, .rx_read, .tx_frame_sync_in,
		.tx_frame_sync_out, .tx_frame_sync_en_b, .serial_data_out,
		.serial_data_out_en_b, .rx_frame_sync, .serial_data_in, .tx_ready_flag,
		.tx_interrupt, .tx_shift_empty_n, .rx_ready_flag, .rx_interrupt,
		.rx_overrun_flag, .rx_data);
	bms_partner bms_partner_i (.tx_bit_clock, .rx_bit_clock, .tx_frame_sync_out,
		.tx_frame_sync_en_b, .serial_data_out, .serial_data_out_en_b,
		.tx_frame_sync_in, .rx_frame_sync, .serial_data_in);

	always #12.5 clk = ~clk;
	always #15 tx_bit_clock = ~tx_bit_clock;
	initial
	begin
		#4;
		forever #15 rx_bit_clock = ~rx_bit_clock;
	end

	// Ceiling well above the several hundred cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		tx_cnt += (tx_interrupt === 1'b1);
		rx_cnt += (rx_interrupt === 1'b1);
		if (cycles == 30000)
		begin
			fails++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask : clks

	task automatic wr(input logic [15:0] d);
		@(negedge clk);
		tx_data = d;
		tx_write = 1'b1;
		@(negedge clk);
		tx_write = 1'b0;
	endtask : wr

	task automatic rd;
		@(negedge clk);
		rx_read = 1'b1;
		@(negedge clk);
		rx_read = 1'b0;
	endtask : rd

	// Settle time covers the configuration synchroniser
	task automatic cfg(input logic s, input logic w, input logic b);
		@(negedge clk);
		frame_sync_source_select = s;
		word_length_select = w;
		buffered_port_variant = b;
		clks(20);
	endtask : cfg

	task automatic wait_int(input bit rx, input int want);
		int k;
		k = 0;
		while ((rx ? rx_cnt : tx_cnt) < want && k < 80)
		begin
			@(negedge clk);
			k++;
		end
		chk((rx ? rx_cnt : tx_cnt) == want, "interrupt count");
	endtask : wait_int

	task automatic t_reset;
		chk(tx_ready_flag === 1'b1 && tx_shift_empty_n === 1'b0, "tx reset flags");
		chk(serial_data_out_en_b === 1'b1 && rx_overrun_flag === 1'b0, "reset");
	endtask : t_reset

	task automatic t_basic_int;
		logic [15:0] w;
		logic ok;
		int c;
		cfg(1'b1, 1'b1, 1'b0);
		c = tx_cnt;
		chk(tx_frame_sync_en_b === 1'b0, "sync pin not driven");
		fork
			bms_partner_i.tx_frame(0, 16, w, ok);
			begin
				wr(16'ha5c3);
				wait_int(1'b0, c + 1);
				clks(4);
				chk(tx_ready_flag === 1'b1 && tx_shift_empty_n === 1'b1, "load");
			end
		join
		chk(ok === 1'b1 && w === 16'ha5c3, "internal frame");
		clks(10);
		chk(tx_shift_empty_n === 1'b0 && serial_data_out_en_b === 1'b1, "idle");
	endtask : t_basic_int

	task automatic t_buf_ext;
		logic [15:0] w;
		logic ok;
		int c;
		cfg(1'b0, 1'b0, 1'b1);
		c = tx_cnt;
		wr(16'h003c);
		clks(40);
		chk(tx_cnt == c && serial_data_out_en_b === 1'b1, "sent early");
		wr(16'h00b6);
		// Let the write cross into the bit clock domain before the sync
		clks(10);
		bms_partner_i.tx_frame(3, 8, w, ok);
		wait_int(1'b0, c + 1);
		// Underflow flag crosses back to the CPU clock
		clks(8);
		chk(ok === 1'b1 && w[7:0] === 8'hb6, "latest word");
		chk(tx_shift_empty_n === 1'b0, "underflow");
		bms_partner_i.tx_frame(1, 8, w, ok);
		clks(10);
		chk(ok === 1'b1 && w[7:0] === 8'hb6 && tx_cnt == c + 1, "stale");
	endtask : t_buf_ext

	task automatic t_basic_ext;
		logic [15:0] w;
		logic ok;
		int c;
		cfg(1'b0, 1'b0, 1'b0);
		c = tx_cnt;
		wr(16'h0011);
		wait_int(1'b0, c + 1);
		wr(16'h0022);
		clks(20);
		wr(16'h0033);
		clks(20);
		chk(tx_cnt == c + 1, "copy while shift register full");
		chk(tx_ready_flag === 1'b0, "ready after write");
		bms_partner_i.tx_frame(1, 8, w, ok);
		chk(ok === 1'b1 && w[7:0] === 8'h11, "first word");
		wait_int(1'b0, c + 2);
		bms_partner_i.tx_frame(1, 8, w, ok);
		chk(ok === 1'b1 && w[7:0] === 8'h33, "overwritten word");
	endtask : t_basic_ext

	task automatic t_rx_basic;
		int c;
		cfg(1'b0, 1'b1, 1'b0);
		c = rx_cnt;
		bms_partner_i.rx_frame(16'h9e37, 16, 1);
		wait_int(1'b1, c + 1);
		chk(rx_data === 16'h9e37 && rx_ready_flag === 1'b1, "word");
		rd;
		bms_partner_i.rx_frame(16'h4b2d, 16, 3);
		wait_int(1'b1, c + 2);
		chk(rx_data === 16'h4b2d && rx_ready_flag === 1'b1, "long sync word");
		bms_partner_i.rx_frame(16'h1234, 16, 1);
		clks(10);
		chk(rx_overrun_flag === 1'b0 && rx_cnt == c + 2, "early overrun");
		bms_partner_i.rx_frame(16'h5555, 16, 1);
		clks(10);
		chk(rx_overrun_flag === 1'b1 && rx_data === 16'h4b2d, "overrun");
		rd;
		clks(16);
		chk(rx_overrun_flag === 1'b0, "overrun after read");
	endtask : t_rx_basic

	task automatic t_rx_buf;
		int c;
		cfg(1'b0, 1'b0, 1'b1);
		c = rx_cnt;
		bms_partner_i.rx_frame(16'h005a, 8, 1);
		wait_int(1'b1, c + 1);
		bms_partner_i.rx_frame(16'h00c3, 8, 1);
		clks(10);
		chk(rx_overrun_flag === 1'b1 && rx_data === 16'h005a, "dropped word");
		chk(rx_cnt == c + 1, "transfer on overrun");
		rd;
		clks(16);
		chk(rx_overrun_flag === 1'b0, "overrun after read");
		bms_partner_i.rx_frame(16'h000f, 8, 1);
		wait_int(1'b1, c + 2);
		chk(rx_data === 16'h000f, "word after read");
	endtask : t_rx_buf

	task automatic t_mode_off;
		int c;
		@(negedge clk);
		frame_sync_mode_select = 1'b0;
		clks(20);
		c = rx_cnt;
		bms_partner_i.rx_frame(16'h00aa, 8, 1);
		clks(20);
		chk(rx_cnt == c, "receive outside burst mode");
	endtask : t_mode_off

	initial
	begin
		clk = 1'b0;
		tx_bit_clock = 1'b0;
		rx_bit_clock = 1'b0;
		rst_b = 1'b0;
		frame_sync_mode_select = 1'b1;
		frame_sync_source_select = 1'b0;
		word_length_select = 1'b1;
		buffered_port_variant = 1'b0;
		tx_write = 1'b0;
		tx_data = 16'h0000;
		rx_read = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		t_reset;
		t_basic_int;
		t_buf_ext;
		t_basic_ext;
		t_rx_basic;
		t_rx_buf;
		t_mode_off;
		wrap_up;
	end
endmodule : test_burst_mode_serial_port
